// ===== verilog/tssc_pkg.sv
// shared constants and types for the two-speed start-up clock switch
package tssc_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses) and field layout
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_OSC_CTRL = 4'h0;
  localparam logic [3:0] OFF_CLK_STATUS = 4'h4;
  localparam int SCS_LSB = 0;
  localparam int PRIMARY_CLOCK_ACTIVE_FLAG_BIT = 3;
  localparam int IFS_LSB = 4;
  localparam logic [1:0] SCS_RST = 2'h0;
  localparam logic [2:0] IFS_RST = 3'h0;
  // ----------------------------------------------------------------
  // settle counter: periods of the primary oscillator
  // ----------------------------------------------------------------
  localparam int OST_PERIODS = 1024;
  localparam int OST_CNT_W = 10;
  // ----------------------------------------------------------------
  // clock source codes, also the system_clock_select encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_PRIMARY = 2'h0;
  localparam logic [1:0] SRC_SECONDARY = 2'h1;
  localparam logic [1:0] SRC_INTERNAL = 2'h2;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_PWRT = 3'b000,
    ST_WAIT_OST = 3'b001,
    ST_INT_START = 3'b010,
    ST_SWITCH = 3'b011,
    ST_PRIMARY_RUN_MODE = 3'b100,
    ST_ALT_RUN = 3'b101,
    ST_PM_WAIT = 3'b110,
    ST_SLEEP = 3'b111
  } tssc_state_t;
endpackage : tssc_pkg

// ===== verilog/tssc_ost_if.sv
// link between sequencer and oscillator settle counter
`timescale 1ns/100ps
interface tssc_ost_if;
  logic start;
  logic done;
  modport ctrl (output start, input done);
  modport cnt (input start, output done);
endinterface : tssc_ost_if

// ===== verilog/tssc_settle_counter.sv
// oscillator settle counter: counts primary oscillator periods
`timescale 1ns/100ps
module tssc_settle_counter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // primary oscillator level, sampled on pclk
  input wire logic primary_osc_clock,
  // sequencer side
  tssc_ost_if.cnt ost
);
  logic prev_ff;
  logic active_ff;
  logic done_ff;
  logic [tssc_pkg::OST_CNT_W-1:0] count_ff;
  logic nxt_active;
  logic nxt_done;
  logic [tssc_pkg::OST_CNT_W-1:0] nxt_count;
  logic rise;

  assign rise = primary_osc_clock & ~prev_ff;
  assign ost.done = done_ff;

  // count rising edges; start restarts from zero and drops done
  always_comb
  begin
    nxt_active = active_ff;
    nxt_done = done_ff;
    nxt_count = count_ff;
    if (ost.start)
    begin
      nxt_active = 1'b1;
      nxt_done = 1'b0;
      nxt_count = '0;
    end
    else if (active_ff && rise)
    begin
      if (count_ff == tssc_pkg::OST_CNT_W'(tssc_pkg::OST_PERIODS - 1))
      begin
        nxt_active = 1'b0;
        nxt_done = 1'b1;
      end
      else
        nxt_count = count_ff + 1'b1;
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_ff <= 1'b0;
      active_ff <= 1'b0;
      done_ff <= 1'b0;
      count_ff <= '0;
    end
    else
    begin
      prev_ff <= primary_osc_clock;
      active_ff <= nxt_active;
      done_ff <= nxt_done;
      count_ff <= nxt_count;
    end
  end

  property p_ost_count;
    @(posedge pclk) disable iff (!presetn)
    $rose(done_ff) |-> $past(count_ff) == 10'd1023 && $past(rise);
  endproperty
  a_ost_count: assert property (p_ost_count)
    else $error("settle done without 1024 periods");
endmodule : tssc_settle_counter

// ===== verilog/tssc_clock_switch.sv
// two-speed start-up sequencer with apb oscillator control register
`timescale 1ns/100ps
// Summary of operation
// - with enable set, run from internal rc until primary is ready
// - with enable set, each reset and sleep wake-up selects internal clock, after pwrt on por
// - settle counter expiry switches to primary run mode automatically when select is primary
// - control register clears on reset, so base rc frequency is used
// - other power modes ignore enable, keep source until primary ready
// - clock select writes and sleep accepted during two-speed start-up
// - read-only bit 3 shows primary clock active
// - settle counter counts 1024 primary periods
module tssc_clock_switch (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration and power events
  input wire logic two_speed_startup_enable,
  input wire logic por_reset_flag,
  input wire logic pwrt_done,
  input wire logic sleep_cmd,
  input wire logic wake_event,
  // oscillator levels, sampled on pclk
  input wire logic internal_base_rc_clock,
  input wire logic primary_osc_clock,
  // clock control outputs
  output logic [1:0] clk_src,
  output logic core_clk_run,
  output logic primary_osc_enable,
  output logic internal_postscaled_clock,
  output logic primary_run_mode
);
  tssc_pkg::tssc_state_t state_ff;
  tssc_pkg::tssc_state_t nxt_state;
  logic [1:0] scs_ff;
  logic [1:0] nxt_scs;
  logic [2:0] ifs_ff;
  logic [2:0] nxt_ifs;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic [1:0] src_ff;
  logic [1:0] nxt_src;
  logic run_ff;
  logic nxt_run;
  logic osc_en_ff;
  logic nxt_osc_en;
  logic post_ff;
  logic nxt_post;
  logic primary_run_mode_ff;
  logic nxt_primary_run_mode;
  logic ost_start;
  logic sw_ok;
  logic wr_ctrl;
  logic setup_rd;
  logic mapped;
  logic primary_clock_active_flag;
  logic [1:0] scs_src;

  tssc_ost_if ost ();

  tssc_settle_counter u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .primary_osc_clock(primary_osc_clock),
    .ost(ost)
  );

  // ----------------------------------------------------------------
  // apb slave: zero wait states, read data latched in setup phase
  // ----------------------------------------------------------------
  assign mapped = paddr[31:4] == 28'h000_0000 && paddr[1:0] == 2'b00
    && (paddr[3:0] == tssc_pkg::OFF_OSC_CTRL
    || paddr[3:0] == tssc_pkg::OFF_CLK_STATUS);
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_ff;
  assign wr_ctrl = psel & penable & pwrite
    & (paddr == 32'(tssc_pkg::OFF_OSC_CTRL));
  assign setup_rd = psel & ~penable & ~pwrite;
  // flag is primary clocking the core
  assign primary_clock_active_flag = src_ff == tssc_pkg::SRC_PRIMARY && run_ff;

  // register writes and read mux; primary_clock_active_flag bit ignores writes
  always_comb
  begin
    nxt_scs = scs_ff;
    nxt_ifs = ifs_ff;
    nxt_prdata = prdata_ff;
    if (wr_ctrl)
    begin
      nxt_scs = pwdata[tssc_pkg::SCS_LSB +: 2];
      nxt_ifs = pwdata[tssc_pkg::IFS_LSB +: 3];
    end
    if (setup_rd)
    begin
      if (paddr == 32'(tssc_pkg::OFF_OSC_CTRL))
        nxt_prdata = {25'h000_0000, ifs_ff, primary_clock_active_flag, 1'b0, scs_ff};
      else if (paddr == 32'(tssc_pkg::OFF_CLK_STATUS))
        nxt_prdata = {26'h000_0000, run_ff, src_ff, state_ff};
      else
        nxt_prdata = 32'h0000_0000;
    end
  end

  // control fields clear on every reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scs_ff <= tssc_pkg::SCS_RST;
      ifs_ff <= tssc_pkg::IFS_RST;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      scs_ff <= nxt_scs;
      ifs_ff <= nxt_ifs;
      prdata_ff <= nxt_prdata;
    end
  end

  // ----------------------------------------------------------------
  // source sequencer
  // ----------------------------------------------------------------
  // both clocks low: no pulse can be cut short by the change
  assign sw_ok = ~internal_base_rc_clock & ~primary_osc_clock;
  assign scs_src = (scs_ff == tssc_pkg::SRC_SECONDARY)
    ? tssc_pkg::SRC_SECONDARY : tssc_pkg::SRC_INTERNAL;

  // next state, source and run controls
  always_comb
  begin
    nxt_state = state_ff;
    nxt_src = src_ff;
    nxt_run = run_ff;
    nxt_osc_en = osc_en_ff;
    ost_start = 1'b0;
    case (state_ff)
      tssc_pkg::ST_PWRT:
      begin
        // internal clock chosen once pwrt expires after por
        if (pwrt_done || !por_reset_flag)
        begin
          ost_start = 1'b1;
          nxt_osc_en = 1'b1;
          // enable runs core from internal rc meanwhile
          if (two_speed_startup_enable)
          begin
            nxt_state = tssc_pkg::ST_INT_START;
            nxt_src = tssc_pkg::SRC_INTERNAL;
            nxt_run = 1'b1;
          end
          else
            nxt_state = tssc_pkg::ST_WAIT_OST;
        end
      end
      tssc_pkg::ST_WAIT_OST:
      begin
        if (ost.done)
        begin
          nxt_state = tssc_pkg::ST_PRIMARY_RUN_MODE;
          nxt_src = tssc_pkg::SRC_PRIMARY;
          nxt_run = 1'b1;
        end
      end
      tssc_pkg::ST_INT_START:
      begin
        // select changes and sleep honoured before expiry
        nxt_src = scs_src;
        if (sleep_cmd)
          nxt_state = tssc_pkg::ST_SLEEP;
        else if (ost.done)
          nxt_state = (scs_ff == tssc_pkg::SRC_PRIMARY)
            ? tssc_pkg::ST_SWITCH : tssc_pkg::ST_ALT_RUN;
      end
      tssc_pkg::ST_SWITCH:
      begin
        // change source only in common low phase
        if (sw_ok)
        begin
          nxt_state = tssc_pkg::ST_PRIMARY_RUN_MODE;
          nxt_src = tssc_pkg::SRC_PRIMARY;
        end
      end
      tssc_pkg::ST_PRIMARY_RUN_MODE:
      begin
        if (sleep_cmd)
          nxt_state = tssc_pkg::ST_SLEEP;
        else if (scs_ff != tssc_pkg::SRC_PRIMARY)
        begin
          nxt_state = tssc_pkg::ST_ALT_RUN;
          nxt_src = scs_src;
        end
      end
      tssc_pkg::ST_ALT_RUN:
      begin
        nxt_src = scs_src;
        if (sleep_cmd)
          nxt_state = tssc_pkg::ST_SLEEP;
        else if (scs_ff == tssc_pkg::SRC_PRIMARY)
        begin
          // enable ignored; hold source until primary settles
          nxt_src = src_ff;
          ost_start = 1'b1;
          nxt_state = tssc_pkg::ST_PM_WAIT;
        end
      end
      tssc_pkg::ST_PM_WAIT:
      begin
        if (sleep_cmd)
          nxt_state = tssc_pkg::ST_SLEEP;
        else if (ost.done)
          nxt_state = tssc_pkg::ST_SWITCH;
      end
      tssc_pkg::ST_SLEEP:
      begin
        nxt_run = 1'b0;
        nxt_osc_en = 1'b0;
        if (wake_event)
        begin
          ost_start = 1'b1;
          nxt_osc_en = 1'b1;
          // wake-up with enable restarts on internal clock
          if (two_speed_startup_enable)
          begin
            nxt_state = tssc_pkg::ST_INT_START;
            nxt_src = tssc_pkg::SRC_INTERNAL;
            nxt_run = 1'b1;
          end
          else
          begin
            nxt_state = tssc_pkg::ST_WAIT_OST;
            nxt_src = tssc_pkg::SRC_PRIMARY;
          end
        end
      end
      default:
        nxt_state = tssc_pkg::ST_PWRT;
    endcase
    // postscaled internal clock only once select is written
    nxt_post = nxt_src == tssc_pkg::SRC_INTERNAL && nxt_ifs != 3'h0;
    nxt_primary_run_mode = nxt_state == tssc_pkg::ST_PRIMARY_RUN_MODE;
  end

  assign ost.start = ost_start;

  // sequencer registers; core clock held until pwrt or settle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= tssc_pkg::ST_PWRT;
      src_ff <= tssc_pkg::SRC_INTERNAL;
      run_ff <= 1'b0;
      osc_en_ff <= 1'b0;
      post_ff <= 1'b0;
      primary_run_mode_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      src_ff <= nxt_src;
      run_ff <= nxt_run;
      osc_en_ff <= nxt_osc_en;
      post_ff <= nxt_post;
      primary_run_mode_ff <= nxt_primary_run_mode;
    end
  end

  assign clk_src = src_ff;
  assign core_clk_run = run_ff;
  assign primary_osc_enable = osc_en_ff;
  assign internal_postscaled_clock = post_ff;
  assign primary_run_mode = primary_run_mode_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_int_start;
    @(posedge pclk) disable iff (!presetn)
    state_ff == tssc_pkg::ST_INT_START |-> run_ff
      && src_ff != tssc_pkg::SRC_PRIMARY;
  endproperty
  a_int_start: assert property (p_int_start)
    else $error("start-up not on internal clock");

  property p_wake_int;
    @(posedge pclk) disable iff (!presetn)
    state_ff == tssc_pkg::ST_SLEEP && wake_event
      && two_speed_startup_enable |=> src_ff == tssc_pkg::SRC_INTERNAL
      && run_ff ##1 !ost.done;
  endproperty
  a_wake_int: assert property (p_wake_int)
    else $error("wake-up did not select internal clock");

  property p_auto_switch;
    @(posedge pclk) disable iff (!presetn)
    state_ff == tssc_pkg::ST_INT_START && ost.done && !sleep_cmd
      && scs_ff == tssc_pkg::SRC_PRIMARY
      |=> state_ff == tssc_pkg::ST_SWITCH;
  endproperty
  a_auto_switch: assert property (p_auto_switch)
    else $error("counter expiry did not start hand-over");

  // hand-over waits for the common low phase, then completes at once
  property p_switch_done;
    @(posedge pclk) disable iff (!presetn)
    state_ff == tssc_pkg::ST_SWITCH && sw_ok
      |=> primary_run_mode && src_ff == tssc_pkg::SRC_PRIMARY;
  endproperty
  a_switch_done: assert property (p_switch_done)
    else $error("no hand-over to primary run mode");

  property p_base_freq;
    @(posedge pclk) disable iff (!presetn)
    ifs_ff == 3'h0 && !wr_ctrl |=> !post_ff;
  endproperty
  a_base_freq: assert property (p_base_freq)
    else $error("postscaler used while select is clear");

  property p_pm_hold;
    @(posedge pclk) disable iff (!presetn)
    state_ff == tssc_pkg::ST_PM_WAIT && !ost.done |=> $stable(src_ff);
  endproperty
  a_pm_hold: assert property (p_pm_hold)
    else $error("source changed before primary ready");

  property p_sleep_accept;
    @(posedge pclk) disable iff (!presetn)
    state_ff == tssc_pkg::ST_INT_START && sleep_cmd
      |=> state_ff == tssc_pkg::ST_SLEEP ##1 !core_clk_run;
  endproperty
  a_sleep_accept: assert property (p_sleep_accept)
    else $error("sleep refused during start-up");

  property p_primary_clock_active_flag_read;
    @(posedge pclk) disable iff (!presetn)
    setup_rd && paddr == 32'h0000_0000
      |=> prdata[3] == $past(primary_clock_active_flag);
  endproperty
  a_primary_clock_active_flag_read: assert property (p_primary_clock_active_flag_read)
    else $error("status flag read wrong");

  property p_glitchless;
    @(posedge pclk) disable iff (!presetn)
    $changed(src_ff) && src_ff == tssc_pkg::SRC_PRIMARY && run_ff
      && $past(run_ff) |-> $past(sw_ok);
  endproperty
  a_glitchless: assert property (p_glitchless)
    else $error("switch outside common low phase");
endmodule : tssc_clock_switch

// ===== sim/tssc_clock_switch_bench.sv
// self-checking bench for the two-speed start-up clock switch
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tssc_clock_switch_bench;
  logic pclk, presetn, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, err;
  logic two_speed_startup_enable, por_reset_flag, pwrt_done;
  logic sleep_cmd, wake_event;
  logic internal_base_rc_clock, primary_osc_clock, pdiv;
  logic [1:0] clk_src;
  logic core_clk_run, primary_osc_enable;
  logic internal_postscaled_clock, primary_run_mode;
  int num_errors = 0;
  int total_checks = 0;
  int rises = 0;
  int r0;

  // ----------------------------------------------------------------
  // clock, oscillator stand-ins and design
  // ----------------------------------------------------------------
  always #50 pclk = ~pclk;

  // primary at pclk/4 so every rise is seen; rises counted here
  always @(posedge pclk)
  begin
    internal_base_rc_clock <= ~internal_base_rc_clock;
    pdiv <= ~pdiv;
    if (pdiv)
    begin
      primary_osc_clock <= ~primary_osc_clock;
      if (!primary_osc_clock)
        rises <= rises + 1;
    end
  end

  tssc_clock_switch uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .two_speed_startup_enable(two_speed_startup_enable),
    .por_reset_flag(por_reset_flag), .pwrt_done(pwrt_done),
    .sleep_cmd(sleep_cmd), .wake_event(wake_event),
    .internal_base_rc_clock(internal_base_rc_clock),
    .primary_osc_clock(primary_osc_clock), .clk_src(clk_src),
    .core_clk_run(core_clk_run), .primary_osc_enable(primary_osc_enable),
    .internal_postscaled_clock(internal_postscaled_clock),
    .primary_run_mode(primary_run_mode)
  );

  // ----------------------------------------------------------------
  // bus and event tasks
  // ----------------------------------------------------------------
  // one apb transfer; request held until pready is seen high
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle event pulse, then let outputs settle
  task pulse(input logic go_sleep);
    @(posedge pclk);
    if (go_sleep)
      sleep_cmd <= 1'b1;
    else
      wake_event <= 1'b1;
    @(posedge pclk);
    sleep_cmd <= 1'b0;
    wake_event <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
  endtask : pulse

  // bounded wait for hand-over to the primary clock
  task wait_pri;
    int k;
    k = 0;
    while (primary_run_mode !== 1'b1 && k < 8000)
    begin
      @(posedge pclk);
      #1;
      k++;
    end
    `CHK(primary_run_mode, 1'b1)
    `CHK(clk_src, tssc_pkg::SRC_PRIMARY)
  endtask : wait_pri

  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    two_speed_startup_enable = 1;
    por_reset_flag = 1;
    pwrt_done = 0;
    sleep_cmd = 0;
    wake_event = 0;
    internal_base_rc_clock = 0;
    primary_osc_clock = 0;
    pdiv = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // power-on reset: held until the power-up timer expires
    apb(1'b0, 32'h0000_0004, 32'h0000_0000);
    `CHK(rd[2:0], tssc_pkg::ST_PWRT)
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    @(posedge pclk);
    pwrt_done <= 1'b1;
    @(posedge pclk);
    r0 = rises;
    repeat (3) @(posedge pclk);
    #1;
    `CHK(clk_src, tssc_pkg::SRC_INTERNAL)
    `CHK(core_clk_run, 1'b1)
    `CHK(internal_postscaled_clock, 1'b0)
    `CHK(primary_run_mode, 1'b0)
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    `CHK(rd[3], 1'b0)
    wait_pri();
    // window allows only the sampling and hand-over slack
    `CHK((rises - r0 >= 1024) && (rises - r0 <= 1027), 1'b1)
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    `CHK(rd[3], 1'b1)
    apb(1'b0, 32'h0000_0004, 32'h0000_0000);
    `CHK(rd[5:0], 6'h24)
    // leave primary for the postscaled internal source
    // select written before sleep
    apb(1'b1, 32'h0000_0000, 32'h0000_005a);
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    `CHK(rd, 32'h0000_0052)
    apb(1'b0, 32'h0000_0008, 32'h0000_0000);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0000_0000)
    // back to primary outside start-up: source held until settled
    apb(1'b1, 32'h0000_0000, 32'h0000_0050);
    apb(1'b0, 32'h0000_0004, 32'h0000_0000);
    `CHK(rd[5:0], 6'h36)
    `CHK(clk_src, tssc_pkg::SRC_INTERNAL)
    wait_pri();
    // sleep and wake: start-up again from the internal source
    pulse(1'b1);
    `CHK(core_clk_run, 1'b0)
    `CHK(primary_osc_enable, 1'b0)
    pulse(1'b0);
    `CHK(clk_src, tssc_pkg::SRC_INTERNAL)
    `CHK(core_clk_run, 1'b1)
    `CHK(internal_postscaled_clock, 1'b1)
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    `CHK(rd[3], 1'b0)
    // a second sleep before the settle count ends is honoured
    pulse(1'b1);
    `CHK(core_clk_run, 1'b0)
    pulse(1'b0);
    // select change before expiry: secondary source taken at once
    apb(1'b1, 32'h0000_0000, 32'h0000_0051);
    apb(1'b0, 32'h0000_0004, 32'h0000_0000);
    `CHK(rd[4:3], tssc_pkg::SRC_SECONDARY)
    apb(1'b1, 32'h0000_0000, 32'h0000_0050);
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    `CHK(rd, 32'h0000_0050)
    wait_pri();
    // second reset with the feature off: no internal start-up
    @(posedge pclk);
    presetn <= 1'b0;
    two_speed_startup_enable <= 1'b0;
    por_reset_flag <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 32'h0000_0004, 32'h0000_0000);
    `CHK(rd[2:0], tssc_pkg::ST_WAIT_OST)
    `CHK(primary_run_mode, 1'b0)
    wait_pri();
    summarize();
  end

  // watchdog: four settle waits take about 17000 cycles
  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    summarize();
  end
endmodule : tssc_clock_switch_bench
